/* File: hw/gdb_brake_ctrl.sv */
`timescale 1ns/100ps
// Operation
// R1 - Gates passively discharged outside Normal Mode; with ov_brake the low sides are driven on and not discharged
// R2 - Slam request honoured only in Normal Mode
// R3 - Slam: active turn-off, then pump off
// R4 - Slam: first PWM pin drives all low sides
// R5 - Slam: PWM high turns low sides on
// R6 - Slam: PWM low turns low sides off
// R7 - Software may exclude low sides from slam
// R8 - Park on sleep/stop: active off, pump off
// R9 - Park: release low-side passive discharge only
// R10 - Park: PWM high turns low sides on
// R11 - Level bit 0: logic-level targets
// R12 - Level bit 1: normal-level common target
// R13 - Auto bit 0: always dual stage
// R14 - Auto bit 1: switch stage by thresholds
// R15 - Modulation bit enables 15.6 kHz modulation
// R16 - Mode field 00 holds gates passive off
// R17 - Brake steps strictly in sequence
module gdb_brake_ctrl #(
	parameter int CCP_NS = gdb_pkg::CCP_TIME_NS
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// Device state and pins
	input wire logic [2:0] op_mode,
	input wire logic first_pwm_input_pin,
	input wire logic second_pwm_input_pin,
	input wire logic ov_brake,
	input wire logic vs_above_upper,
	input wire logic vs_below_lower,
	// Gate drive
	output logic [3:0] hs_on,
	output logic [3:0] low_side_driver,
	output logic [3:0] hs_active_off,
	output logic [3:0] ls_active_off,
	output logic [3:0] hs_passive_dis,
	output logic [3:0] ls_passive_dis,
	// Charge pump
	output logic cp_on,
	output logic cp_single_stage,
	output logic cp_target_high,
	output logic gate_target_common,
	output logic cp_mod_clk
);
	import gdb_pkg::*;

	localparam int CCP_CYC = (CCP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

	typedef enum logic [2:0] {
		GDB_IDLE, GDB_SLAM_OFF, GDB_SLAM_CP, GDB_SLAM, GDB_PARK_OFF, GDB_PARK_CP, GDB_PARK_REL, GDB_PARK
	} gdb_state_e;

	// Mode field that actively drives one side of its bridge
	function automatic logic driven(input logic [1:0] m);
		driven = (m == HBM_LS) || (m == HBM_HS);
	endfunction : driven

	logic [CTL_W-1:0] general_control_register;
	logic [BCF_W-1:0] bridge_cfg_r;
	logic [3:0] slam_excl_r;
	gdb_state_e state_r, state_nxt;
	logic [15:0] ccp_cnt_r;
	logic [2:0] op_mode_r;
	logic single_r, single_nxt;
	logic [3:0] hs_nxt, ls_nxt, hao_nxt, lao_nxt, hpd_nxt, lpd_nxt;
	logic cp_nxt;
	logic [31:0] rdata_nxt;
	logic fm_clk;

	// Named control fields
	wire charge_pump_enable_bit = general_control_register[CTL_CP_EN];
	wire slam_req = general_control_register[CTL_SLAM];
	wire parking_brake_enable = general_control_register[CTL_PARK_EN];
	wire mosfet_level_select = general_control_register[CTL_MOSFET_LEVEL_SELECT];
	wire charge_pump_stage_auto = general_control_register[CTL_STAGE_AUTO];
	wire pump_frequency_modulation_bit = general_control_register[CTL_PUMP_FREQUENCY_MODULATION_BIT];
	wire [3:0] bridge_pwm_enable = bridge_cfg_r[BCF_PWM_EN +: 4];
	wire pwm_map_bridges_one_two = bridge_cfg_r[BCF_MAP12];
	wire pwm_map_bridges_three_four = bridge_cfg_r[BCF_MAP34];
	wire in_normal = (op_mode == OPM_NORMAL);
	wire low_power = (op_mode == OPM_SLEEP) || (op_mode == OPM_STOP);
	wire park_entry = low_power && (op_mode_r != op_mode) && parking_brake_enable;
	wire ccp_done = (ccp_cnt_r == 16'(CCP_CYC - 1));
	wire in_act_off = (state_r == GDB_SLAM_OFF) || (state_r == GDB_PARK_OFF);
	wire in_slam = (state_r == GDB_SLAM_OFF) || (state_r == GDB_SLAM_CP) || (state_r == GDB_SLAM);
	wire in_park = (state_r == GDB_PARK_OFF) || (state_r == GDB_PARK_CP) || (state_r == GDB_PARK_REL)
		|| (state_r == GDB_PARK);

	// Register write decode
	wire wr_ctl = reg_wr && (reg_addr == ADDR_GEN_CTRL);
	wire wr_bcf = reg_wr && (reg_addr == ADDR_BRIDGE_CFG);
	wire wr_exc = reg_wr && (reg_addr == ADDR_SLAM_EXCL);

	// Software registers
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			general_control_register <= CTL_RESET;
			bridge_cfg_r <= BCF_RESET;
			slam_excl_r <= 4'h0;
		end else begin
			if (wr_ctl) general_control_register <= reg_wdata[CTL_W-1:0];
			if (wr_bcf) bridge_cfg_r <= reg_wdata[BCF_W-1:0];
			if (wr_exc) slam_excl_r <= reg_wdata[3:0];
		end
	end

	// Read mux, answer stands in the cycle after the strobe
	always_comb begin
		rdata_nxt = 32'h00000000;
		if (reg_rd) begin
			unique case (reg_addr)
				ADDR_GEN_CTRL: rdata_nxt[CTL_W-1:0] = general_control_register;
				ADDR_BRIDGE_CFG: rdata_nxt[BCF_W-1:0] = bridge_cfg_r;
				ADDR_SLAM_EXCL: rdata_nxt[3:0] = slam_excl_r;
				ADDR_STATUS: begin
					rdata_nxt[3:0] = low_side_driver;
					rdata_nxt[7:4] = hs_on;
					rdata_nxt[STS_CP_ON] = cp_on;
					rdata_nxt[STS_SINGLE] = cp_single_stage;
					rdata_nxt[STS_SLAM_ACT] = in_slam;
					rdata_nxt[STS_PARK_ACT] = in_park;
					rdata_nxt[STS_SEQ_BUSY] = in_act_off;
				end
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	// Brake sequencer: each step waits for the one before
	always_comb begin
		state_nxt = state_r;
		unique case (state_r)
			GDB_IDLE: begin
				if (in_normal && slam_req) state_nxt = GDB_SLAM_OFF; // [R2]
				else if (park_entry) state_nxt = GDB_PARK_OFF; // [R8]
			end
			GDB_SLAM_OFF: if (ccp_done) state_nxt = GDB_SLAM_CP; // [R3] [R17]
			GDB_SLAM_CP: state_nxt = GDB_SLAM; // [R17]
			GDB_SLAM: state_nxt = GDB_SLAM;
			GDB_PARK_OFF: if (ccp_done) state_nxt = GDB_PARK_CP; // [R8] [R17]
			GDB_PARK_CP: state_nxt = GDB_PARK_REL;
			GDB_PARK_REL: state_nxt = GDB_PARK; // [R17]
			GDB_PARK: state_nxt = GDB_PARK;
		endcase
		// Leaving the mode ends either brake; dropping the request ends only a slam
		if (in_slam && !(in_normal && slam_req)) state_nxt = GDB_IDLE; // [R2]
		if (in_park && !low_power) state_nxt = GDB_IDLE;
	end

	// Sequencer state, cross-current timer, mode history
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			state_r <= GDB_IDLE;
			ccp_cnt_r <= 16'h0000;
			op_mode_r <= OPM_INIT;
		end else begin
			state_r <= state_nxt;
			ccp_cnt_r <= (in_act_off && !ccp_done && state_nxt == state_r) ? ccp_cnt_r + 16'h0001 : 16'h0000;
			op_mode_r <= op_mode;
		end
	end

	// Charge pump stage hysteresis
	always_comb begin
		single_nxt = single_r;
		if (!charge_pump_stage_auto) single_nxt = 1'b0; // [R13]
		else if (vs_above_upper) single_nxt = 1'b1; // [R14]
		else if (vs_below_lower) single_nxt = 1'b0; // [R14]
	end

	// Pump runs in Normal Mode, or through a park entry as held below, and never once a brake has passed its turn-off step
	// On park entry it keeps its state through the active turn-off, and only then goes off
	wire cp_park_hold = cp_on && ((state_r == GDB_IDLE && park_entry) || state_r == GDB_PARK_OFF); // [R8]
	assign cp_nxt = (charge_pump_enable_bit && in_normal && (state_r == GDB_IDLE || state_r == GDB_SLAM_OFF))
		|| cp_park_hold; // [R3] [R8]

	// Per-bridge gate decisions
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_br
			wire [1:0] hbm = bridge_cfg_r[2*gi +: 2];
			wire pwm_sel = (gi < 2) ? pwm_map_bridges_one_two : pwm_map_bridges_three_four;
			wire pwm_src = pwm_sel ? second_pwm_input_pin : first_pwm_input_pin;
			wire drv = bridge_pwm_enable[gi] ? pwm_src : 1'b1;
			wire ls_norm = (hbm == HBM_LS) && charge_pump_enable_bit;
			wire hs_norm = (hbm == HBM_HS) && charge_pump_enable_bit;
			always_comb begin
				hs_nxt[gi] = 1'b0;
				ls_nxt[gi] = 1'b0;
				hao_nxt[gi] = 1'b0;
				lao_nxt[gi] = 1'b0;
				hpd_nxt[gi] = 1'b1; // [R1]
				lpd_nxt[gi] = 1'b1; // [R1]
				unique case (state_r)
					GDB_IDLE: begin
						if (in_normal) begin
							// Field 00 or pump off leaves both gates on passive discharge
							hs_nxt[gi] = hs_norm && drv; // [R16]
							ls_nxt[gi] = ls_norm && drv; // [R16]
							hpd_nxt[gi] = !hs_norm; // [R16]
							lpd_nxt[gi] = !ls_norm; // [R16]
						end else if (ov_brake) begin
							ls_nxt[gi] = 1'b1; // [R1]
							lpd_nxt[gi] = 1'b0;
						end
					end
					GDB_SLAM_OFF, GDB_PARK_OFF: begin
						hao_nxt[gi] = driven(hbm) && (hbm == HBM_HS); // [R3] [R8]
						lao_nxt[gi] = driven(hbm) && (hbm == HBM_LS); // [R3] [R8]
						hpd_nxt[gi] = !(driven(hbm) && (hbm == HBM_HS));
						lpd_nxt[gi] = !(driven(hbm) && (hbm == HBM_LS));
					end
					GDB_SLAM: begin
						ls_nxt[gi] = !slam_excl_r[gi] && first_pwm_input_pin; // [R4] [R5] [R6] [R7]
						lpd_nxt[gi] = slam_excl_r[gi]; // [R7]
					end
					GDB_PARK_REL: lpd_nxt[gi] = 1'b0; // [R9]
					GDB_PARK: begin
						ls_nxt[gi] = first_pwm_input_pin; // [R10]
						lpd_nxt[gi] = 1'b0; // [R9]
					end
					GDB_SLAM_CP, GDB_PARK_CP: begin
					end
				endcase
			end
		end
	endgenerate

	// Output flops
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			hs_on <= 4'h0;
			low_side_driver <= 4'h0;
			hs_active_off <= 4'h0;
			ls_active_off <= 4'h0;
			hs_passive_dis <= 4'hf;
			ls_passive_dis <= 4'hf;
			cp_on <= 1'b0;
			single_r <= 1'b0;
			cp_target_high <= 1'b0;
			gate_target_common <= 1'b0;
			reg_rdata <= 32'h00000000;
		end else begin
			hs_on <= hs_nxt;
			low_side_driver <= ls_nxt;
			hs_active_off <= hao_nxt;
			ls_active_off <= lao_nxt;
			hs_passive_dis <= hpd_nxt;
			ls_passive_dis <= lpd_nxt;
			cp_on <= cp_nxt;
			single_r <= single_nxt;
			cp_target_high <= mosfet_level_select; // [R11] [R12]
			gate_target_common <= mosfet_level_select; // [R11] [R12]
			reg_rdata <= rdata_nxt;
		end
	end
	assign cp_single_stage = single_r;

	// Modulation of the pump clock
	gdb_fm_gen #(.HALF_CYC(FM_HALF_CYC)) u_fm (
		.clk(clk),
		.rst_b(rst_b),
		.enable(pump_frequency_modulation_bit), // [R15]
		.mod_clk(fm_clk)
	);
	always_ff @(posedge clk) begin
		if (!rst_b) cp_mod_clk <= 1'b0;
		else cp_mod_clk <= fm_clk;
	end

	// Cycles spent so far in the active turn-off step, kept apart from the sequencer timer
	logic [15:0] aoff_len_r;
	always_ff @(posedge clk) begin
		if (!rst_b || !in_act_off) begin
			aoff_len_r <= 16'h0000;
		end else begin
			aoff_len_r <= aoff_len_r + 16'h0001;
		end
	end

	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	chk_slam_normal_only: assert property ((state_r == GDB_IDLE && !in_normal) |=> !in_slam) // [R2]
		else $error("slam started outside normal mode");
	chk_slam_pump_off: assert property ((state_r == GDB_SLAM && $past(state_r) == GDB_SLAM) |-> !cp_on) // [R3]
		else $error("pump still on during slam");
	chk_slam_follow: assert property ((state_r == GDB_SLAM && state_nxt == GDB_SLAM && !slam_excl_r[0])
		|=> low_side_driver[0] == $past(first_pwm_input_pin)) // [R4] [R5] [R6]
		else $error("low side not following pwm in slam");
	chk_slam_excluded: assert property ((state_r == GDB_SLAM && slam_excl_r != 4'h0) // [R7]
		|=> (low_side_driver & $past(slam_excl_r)) == 4'h0)
		else $error("excluded low side driven in slam");
	chk_act_off_len: assert property ((in_act_off && state_nxt != state_r && state_nxt != GDB_IDLE) // [R3] [R8]
		|-> aoff_len_r == 16'(CCP_CYC - 1))
		else $error("active turn-off cut short");
	chk_park_hs_passive: assert property ((state_r == GDB_PARK) |=> hs_passive_dis == 4'hf && !cp_on) // [R9]
		else $error("park brake left high side undischarged");
	chk_park_ls: assert property ((state_r == GDB_PARK && state_nxt == GDB_PARK)
		|=> low_side_driver == {4{$past(first_pwm_input_pin)}}) // [R10]
		else $error("park low sides not following pwm");
	chk_stage_dual: assert property (!charge_pump_stage_auto |=> !cp_single_stage) // [R13]
		else $error("single stage without auto select");
	chk_level_map: assert property (##1 cp_target_high == $past(mosfet_level_select)) // [R11] [R12]
		else $error("level targets not following select bit");
	chk_mode_off: assert property ((in_normal && state_r == GDB_IDLE && bridge_cfg_r[5:4] == HBM_OFF) // [R16]
		|=> hs_passive_dis[2] && ls_passive_dis[2] && !hs_on[2] && !low_side_driver[2])
		else $error("bridge with field 00 not held off");
	chk_no_early_route: assert property ((in_slam && state_r != GDB_SLAM) |=> low_side_driver == 4'h0) // [R17]
		else $error("pwm routed before pump off");

	// Quiet modes, overvoltage braking, slam active turn-off and the park sequence
	chk_quiet_passive: assert property ((state_r == GDB_IDLE && !in_normal && !ov_brake) // [R1]
		|=> hs_passive_dis == 4'hf && ls_passive_dis == 4'hf && hs_on == 4'h0 && low_side_driver == 4'h0)
		else $error("gates not passive outside normal mode");
	chk_ov_brake_ls: assert property ((state_r == GDB_IDLE && !in_normal && ov_brake) // [R1]
		|=> low_side_driver == 4'hf && ls_passive_dis == 4'h0 && hs_passive_dis == 4'hf)
		else $error("overvoltage braking not on low sides");
	chk_slam_off_drive: assert property ((state_r == GDB_SLAM_OFF && bridge_cfg_r[1:0] == HBM_LS) // [R3]
		|=> ls_active_off[0] && !low_side_driver[0])
		else $error("low side not actively turned off");
	chk_park_pump_held: assert property ((state_r == GDB_PARK_OFF && $past(state_r) == GDB_IDLE) // [R8]
		|-> cp_on == $past(cp_on))
		else $error("pump dropped before active turn-off");
	chk_park_release: assert property ((state_r == GDB_PARK_REL) |=> !cp_on && ls_passive_dis == 4'h0) // [R8] [R9]
		else $error("park release step out of order");

	// Pump settings
	chk_stage_single: assert property ((charge_pump_stage_auto && vs_above_upper) |=> cp_single_stage) // [R14]
		else $error("no single stage above upper threshold");
	chk_fm_parked: assert property ((!pump_frequency_modulation_bit ##1 !pump_frequency_modulation_bit) // [R15]
		|=> !cp_mod_clk)
		else $error("pump clock modulated while disabled");

	cov_slam: cover property (state_r == GDB_SLAM_CP ##1 state_r == GDB_SLAM);
	cov_park: cover property (state_r == GDB_PARK_REL ##1 state_r == GDB_PARK);
	cov_stage: cover property ($rose(cp_single_stage));
	cov_excluded: cover property (state_r == GDB_SLAM && slam_excl_r != 4'h0);
	cov_ov_brake: cover property (state_r == GDB_IDLE && !in_normal && ov_brake);
endmodule : gdb_brake_ctrl

/* File: common/gdb_pkg.sv */
package gdb_pkg;
	// Operating modes presented by the system mode controller
	localparam logic [2:0] OPM_INIT = 3'h0;
	localparam logic [2:0] OPM_NORMAL = 3'h1;
	localparam logic [2:0] OPM_STOP = 3'h2;
	localparam logic [2:0] OPM_SLEEP = 3'h3;
	localparam logic [2:0] OPM_FAILSAFE = 3'h4;
	localparam logic [2:0] OPM_RESTART = 3'h5;
	// Half-bridge mode field encodings
	localparam logic [1:0] HBM_OFF = 2'h0;
	localparam logic [1:0] HBM_LS = 2'h1;
	localparam logic [1:0] HBM_HS = 2'h2;
	// Register byte addresses
	localparam logic [7:0] ADDR_GEN_CTRL = 8'h00;
	localparam logic [7:0] ADDR_BRIDGE_CFG = 8'h04;
	localparam logic [7:0] ADDR_SLAM_EXCL = 8'h08;
	localparam logic [7:0] ADDR_STATUS = 8'h0c;
	// General control field positions
	localparam int CTL_CP_EN = 0;
	localparam int CTL_SLAM = 1;
	localparam int CTL_PARK_EN = 2;
	localparam int CTL_MOSFET_LEVEL_SELECT = 3;
	localparam int CTL_STAGE_AUTO = 4;
	localparam int CTL_PUMP_FREQUENCY_MODULATION_BIT = 5;
	localparam int CTL_W = 6;
	localparam logic [5:0] CTL_RESET = 6'h21;
	// Bridge configuration field positions
	localparam int BCF_PWM_EN = 8;
	localparam int BCF_MAP12 = 12;
	localparam int BCF_MAP34 = 13;
	localparam int BCF_W = 14;
	localparam logic [13:0] BCF_RESET = 14'h0000;
	// Status field positions
	localparam int STS_CP_ON = 8;
	localparam int STS_SINGLE = 9;
	localparam int STS_SLAM_ACT = 10;
	localparam int STS_PARK_ACT = 11;
	localparam int STS_SEQ_BUSY = 12;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int CCP_TIME_NS = 500;
	localparam int FM_FREQ_HZ = 15600;
	localparam int FM_HALF_CYC = 1000000000 / (FM_FREQ_HZ * 2 * CLK_PERIOD_NS);
endpackage : gdb_pkg

/* File: hw/gdb_fm_gen.sv */
`timescale 1ns/100ps
// Square wave that modulates the charge pump clock
module gdb_fm_gen #(
	parameter int HALF_CYC = gdb_pkg::FM_HALF_CYC
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Control and output
	input wire logic enable,
	output logic mod_clk
);
	import gdb_pkg::*;
	logic [12:0] cnt_r;
	logic wrap;
	assign wrap = (cnt_r == 13'(HALF_CYC - 1));
	// Toggle every half period while enabled, park low otherwise
	always_ff @(posedge clk) begin
		if (!rst_b || !enable) begin
			cnt_r <= 13'h0000;
			mod_clk <= 1'b0;
		end else begin
			cnt_r <= wrap ? 13'h0000 : cnt_r + 13'h0001;
			if (wrap) begin
				mod_clk <= ~mod_clk;
			end
		end
	end
endmodule : gdb_fm_gen

/* File: verification/gdb_host_model.sv */
`timescale 1ns/100ps
// Host side of the register port, driving one access at a time
module gdb_host_model (
	// Clock
	input wire logic clk,
	// Register port
	output logic [7:0] reg_addr,
	output logic [31:0] reg_wdata,
	output logic reg_wr,
	output logic reg_rd,
	input wire logic [31:0] reg_rdata
);
	// Idle bus at time zero
	initial begin
		reg_addr = 8'h00;
		reg_wdata = 32'h0000_0000;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
	end
	// One-cycle write strobe beside address and data
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= v;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
		reg_wdata <= ~v; // Stale data must not look valid
	endtask : wr
	// Read data are taken in the one cycle after the strobe
	task automatic rd(input logic [7:0] a, output logic [31:0] v);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1;
		v = reg_rdata;
	endtask : rd
endmodule : gdb_host_model

/* File: verification/gdb_brake_ctrl_tb_top.sv */
`timescale 1ns/100ps
// Compare helper and bounded wait helper
`define CHK(a, b) begin samples_checked++; \
	if ((a) !== (b)) begin n_fail++; \
	$display("MISMATCH t=%0t got=%h exp=%h", $time, (a), (b)); end end
`define WAITF(c) begin k = 0; \
	while ((c) !== 1'b1 && k < 40) begin step(1); k++; end end
module gdb_brake_ctrl_tb_top;
	import gdb_pkg::*;
	logic clk, rst_b, reg_wr, reg_rd, pwm1, pwm2, ov_brake, vs_up, vs_lo;
	logic [7:0] reg_addr;
	logic [31:0] reg_wdata, reg_rdata, d;
	logic [2:0] op_mode;
	logic [3:0] hs_on, ls_on, hs_aoff, ls_aoff, hs_pdis, ls_pdis;
	logic cp_on, cp_single, cp_th, gt_com, cp_mod;
	int n_fail = 0;
	int samples_checked = 0;
	int cyc_cnt = 0;
	int k, n;
	logic [2:0] quiet_modes [5] = '{OPM_INIT, OPM_STOP, OPM_SLEEP, OPM_FAILSAFE, OPM_RESTART};
	logic [2:0] park_modes [2] = '{OPM_SLEEP, OPM_STOP};
	// 100 MHz clock
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// Short active-off time keeps the brake sequences brief
	gdb_brake_ctrl #(.CCP_NS(20)) dut (.clk(clk), .rst_b(rst_b), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.op_mode(op_mode), .first_pwm_input_pin(pwm1), .second_pwm_input_pin(pwm2),
		.ov_brake(ov_brake), .vs_above_upper(vs_up), .vs_below_lower(vs_lo), .hs_on(hs_on),
		.low_side_driver(ls_on), .hs_active_off(hs_aoff), .ls_active_off(ls_aoff),
		.hs_passive_dis(hs_pdis), .ls_passive_dis(ls_pdis), .cp_on(cp_on),
		.cp_single_stage(cp_single), .cp_target_high(cp_th), .gate_target_common(gt_com),
		.cp_mod_clk(cp_mod));
	gdb_host_model host (.clk(clk), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	// Let edges pass, then settle
	task automatic step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : step
	// Device state and pins change together at a clock edge
	task automatic drv(input logic [2:0] m, input logic p1, input logic p2, input logic ov,
		input logic up, input logic lo);
		@(posedge clk);
		op_mode <= m;
		pwm1 <= p1;
		pwm2 <= p2;
		ov_brake <= ov;
		vs_up <= up;
		vs_lo <= lo;
	endtask : drv
	// Counts and verdict
	task automatic conclude();
		$display("checks %0d mismatches %0d", samples_checked, n_fail);
		if (n_fail == 0 && samples_checked > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : conclude
	// Hang guard
	always @(posedge clk) begin
		cyc_cnt++;
		if (cyc_cnt == 40000) begin
			n_fail++;
			conclude();
		end
	end
	// Test sequence
	initial begin
		rst_b = 1'b0;
		op_mode = OPM_INIT;
		{pwm1, pwm2, ov_brake, vs_up, vs_lo} = 5'h00;
		repeat (20) @(posedge clk);
		rst_b <= 1'b1;
		step(1);
		`CHK({hs_pdis, ls_pdis, cp_on}, 9'h1fe)
		host.rd(ADDR_GEN_CTRL, d);
		`CHK(d, 32'h0000_0021)
		host.rd(ADDR_BRIDGE_CFG, d);
		`CHK(d, 32'h0000_0000)
		host.rd(ADDR_SLAM_EXCL, d);
		`CHK(d, 32'h0000_0000)
		host.rd(8'h10, d);
		`CHK(d, 32'h0000_0000)
		$display("test reset done");
		// Slam requested outside Normal Mode: gates stay passive
		host.wr(ADDR_GEN_CTRL, 32'h23);
		host.wr(ADDR_BRIDGE_CFG, 32'h49);
		host.wr(ADDR_SLAM_EXCL, 32'h4);
		for (int i = 0; i < 5; i++) begin
			drv(quiet_modes[i], 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
			step(4);
			`CHK({hs_pdis, ls_pdis}, 8'hff)
			`CHK({hs_on, ls_on, hs_aoff, ls_aoff, cp_on}, 17'h0)
		end
		// Overvoltage braking turns low sides on outside Normal Mode
		drv(OPM_STOP, 1'b1, 1'b0, 1'b1, 1'b1, 1'b0);
		step(3);
		`CHK({ls_on, ls_pdis, hs_pdis}, 12'hf0f)
		host.wr(ADDR_GEN_CTRL, 32'h21);
		$display("test quiet modes done");
		// Normal Mode static drive, bridge three held off
		drv(OPM_NORMAL, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		step(3);
		`CHK({hs_on, ls_on}, 8'h29)
		`CHK({hs_pdis[2], ls_pdis[2]}, 2'b11)
		host.wr(ADDR_BRIDGE_CFG, 32'h1149);
		step(3);
		`CHK(ls_on, 4'b1000)
		// Slam: active off, pump off, then first PWM pin on low sides
		host.wr(ADDR_GEN_CTRL, 32'h23);
		`WAITF(ls_aoff != 4'h0)
		`CHK({hs_aoff, ls_aoff, cp_on}, 9'h053)
		`WAITF(cp_on == 1'b0)
		`CHK(ls_on, 4'h0)
		step(3);
		`CHK(ls_on, 4'b1011)
		host.rd(ADDR_STATUS, d);
		`CHK(d[STS_SLAM_ACT], 1'b1)
		drv(OPM_NORMAL, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0);
		step(2);
		`CHK(ls_on, 4'h0)
		drv(OPM_NORMAL, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
		step(2);
		`CHK(ls_on, 4'b1011)
		$display("test slam done");
		// Parking brake on entry to Sleep and Stop
		host.wr(ADDR_GEN_CTRL, 32'h25);
		step(3);
		for (int i = 0; i < 2; i++) begin
			drv(park_modes[i], 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
			`WAITF(ls_aoff != 4'h0)
			`CHK({hs_aoff, ls_aoff}, 8'h29)
			`WAITF(ls_aoff == 4'h0)
			`WAITF(ls_pdis == 4'h0)
			`CHK({cp_on, ls_on, hs_pdis}, 9'h00f)
			step(2);
			`CHK(ls_on, 4'hf)
			drv(OPM_NORMAL, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0);
			step(3);
		end
		$display("test park done");
		// Level targets and stage selection
		host.wr(ADDR_GEN_CTRL, 32'h21);
		step(2);
		`CHK({cp_th, gt_com, cp_single}, 3'b000)
		host.wr(ADDR_GEN_CTRL, 32'h39);
		step(2);
		`CHK({cp_th, gt_com, cp_single}, 3'b111)
		drv(OPM_NORMAL, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1);
		step(2);
		`CHK(cp_single, 1'b0)
		$display("test pump settings done");
		// Modulation half period, then no modulation
		k = 0;
		while (cp_mod !== 1'b0 && k < 7000) begin step(1); k++; end
		while (cp_mod !== 1'b1 && k < 7000) begin step(1); k++; end
		n = 0;
		while (cp_mod === 1'b1 && n < 7000) begin step(1); n++; end
		`CHK(n, FM_HALF_CYC)
		host.wr(ADDR_GEN_CTRL, 32'h19);
		step(2);
		n = 0;
		repeat (3500) begin d[0] = cp_mod; step(1); if (cp_mod !== d[0]) n++; end
		`CHK(n, 0)
		$display("test modulation done");
		conclude();
	end
endmodule : gdb_brake_ctrl_tb_top
